// ### hw/lock_host.sv
// Host controller that configures the status pin and manages flash lock bits.
// Function
// - Config command then code; bit0 erase, bit1 program.
// - Host checks ready bit before configuring.
// - Lock set is setup write then confirm write.
// - Aborted clear leaves locks unknown; host repeats. The controller only sets unk_q; software must order the clear again.
// - Config byte B8h, code second, upper bits zero.
//
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "lock_host_params.svh"
module lock_host
  import lock_host_pkg::*;
#(
  parameter int AW = 23 // Flash address width.
) (
  input wire logic mclk_i, // System clock, 20 MHz.
  input wire logic reset_n_i, // Asynchronous reset, active low.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [7:0] wb_adr_i, // Wishbone byte address.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  input wire logic [3:0] wb_sel_i, // Wishbone byte enables.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  output logic [AW-1:0] flash_addr_o, // Flash address.
  input wire logic [7:0] flash_dq_i, // Flash data in.
  output logic [7:0] flash_dq_o, // Flash data out.
  output logic flash_dq_oe_n_o, // Data drive enable, low drives.
  output logic flash_ce_n_o, // Chip enable, active low.
  output logic flash_oe_n_o, // Output enable, active low.
  output logic flash_we_n_o, // Write strobe, active low.
  output logic reset_powerdown_pin_n_o, // Flash reset, active low.
  output logic override_high_voltage_o, // Request override voltage.
  input wire logic status_out_pin_i, // Flash status pin level.
  output logic busy_o // Sequence in progress.
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  localparam logic [3:0] STB = 4'(`STROBE_CYC + 1);
  logic [1:0] rst_sync_q; // Release synchroniser.
  logic rst_n; // Synchronised reset, active low.

  // The reset asserts at once but leaves on the clock, twice flopped.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ------------------------------------------------------------
  // Wishbone register file
  // ------------------------------------------------------------
  op_t op_q, op_d; // Ordered operation.
  logic [31:0] addr_q, addr_d; // Target flash address.
  logic [1:0] code_q, code_d; // Status pin code.
  logic [1:0] pins_q, pins_d; // Reset and override controls.
  logic ack_q, ack_d; // Registered acknowledge.
  logic [31:0] rdat_q, rdat_d; // Registered read data.
  logic go; // Start pulse.
  logic [7:0] sr_q, sr_d; // Last status byte read.
  logic refused_q, refused_d; // Flash was busy at the check.
  logic unk_q, unk_d; // Lock values unknown.
  logic done_q, done_d; // Last sequence finished.
  // Merges written byte lanes into an old word.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i+:8] = n[8*i+:8];
      end
    end
    return r;
  endfunction : merge
  // Decode the bus; each access is acked one cycle later, for one cycle.
  always_comb begin
    logic [31:0] c;
    logic req, wr;
    c = merge(32'h0, wb_dat_i, wb_sel_i);
    req = wb_cyc_i && wb_stb_i && !ack_q;
    wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q; // Writes land as the master sees ack.
    op_d = op_q;
    addr_d = addr_q;
    code_d = code_q;
    pins_d = pins_q;
    go = 1'b0;
    ack_d = req;
    rdat_d = rdat_q;
    if (wr) begin
      unique case (wb_adr_i)
        `REG_CTRL: begin
          // A start while busy is dropped so op_q never changes during a sequence.
          if (wb_sel_i[0] && !busy_o) begin
            op_d = op_t'(c[2:0]);
            go = c[`CTRL_GO];
          end
        end
        `REG_ADDR: addr_d = merge(addr_q, wb_dat_i, wb_sel_i);
        `REG_CODE: if (wb_sel_i[0]) code_d = c[1:0];
        `REG_PINS: if (wb_sel_i[0]) pins_d = c[1:0];
        default: ;
      endcase
    end else if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        `REG_CTRL: rdat_d = {29'h0, op_q};
        `REG_ADDR: rdat_d = addr_q;
        `REG_CODE: rdat_d = {30'h0, code_q};
        `REG_PINS: rdat_d = {29'h0, status_out_pin_i, pins_q};
        `REG_STAT: rdat_d = {20'h0, unk_q, refused_q, done_q, busy_o, sr_q};
        default: rdat_d = 32'h0;
      endcase
    end
  end

  // Register the bus state.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= OP_READ_SR;
      addr_q <= 32'h0;
      code_q <= `CODE_RST;
      pins_q <= `PINS_RST;
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      op_q <= op_d;
      addr_q <= addr_d;
      code_q <= code_d;
      pins_q <= pins_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign flash_addr_o = addr_q[AW-1:0];
  assign reset_powerdown_pin_n_o = pins_q[`PINS_RESET];
  assign override_high_voltage_o = pins_q[`PINS_HV];

  // ------------------------------------------------------------
  // Flash command sequencer
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_PCMD, ST_PRD, ST_SETUP, ST_CONF, ST_POLL, ST_DONE
  } st_t;
  st_t st_q, st_d; // Sequencer state.
  logic [3:0] cnt_q, cnt_d; // Cycle within an access.
  logic acc_end; // Last cycle of an access.
  logic strobe; // Strobe window inside an access.
  logic we_n_q, we_n_d; // Registered write strobe.
  logic oe_n_q, oe_n_d; // Registered output enable.
  logic ce_n_q, ce_n_d; // Registered chip enable.
  logic dqoe_n_q, dqoe_n_d; // Registered drive enable.
  logic [7:0] dq_q, dq_d; // Registered data out.
  // Each access spends cycle 0 settling address and data, holds the
  // strobe in the middle and releases it before the last cycle ends.
  always_comb begin
    st_d = st_q;
    sr_d = sr_q;
    refused_d = refused_q;
    unk_d = unk_q;
    done_d = done_q;
    acc_end = (cnt_q == STB);
    strobe = (cnt_q != 4'h0) && !acc_end;
    cnt_d = acc_end ? 4'h0 : cnt_q + 4'h1;
    we_n_d = 1'b1;
    oe_n_d = 1'b1;
    dqoe_n_d = 1'b1;
    dq_d = `CMD_READ_SR;
    ce_n_d = (st_q == ST_IDLE) || (st_q == ST_DONE);
    unique case (st_q)
      ST_IDLE: begin
        cnt_d = 4'h0;
        if (go) begin
          st_d = ST_PCMD;
          done_d = 1'b0;
          refused_d = 1'b0;
        end
      end
      ST_PCMD: begin
        dqoe_n_d = 1'b0;
        we_n_d = !strobe;
        if (acc_end) st_d = ST_PRD;
      end
      ST_PRD: begin
        oe_n_d = !strobe;
        if (acc_end) begin
          sr_d = flash_dq_i;
          // Nothing is written while the flash is busy or suspended.
          if (!flash_dq_i[`SR_READY]) begin
            refused_d = 1'b1;
            st_d = ST_DONE;
          end else if (op_q > OP_CLEAR) begin // Unknown codes never reach the flash.
            st_d = ST_DONE;
          end else begin
            st_d = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        dqoe_n_d = 1'b0;
        we_n_d = !strobe;
        // The configuration byte leads; lock commands share one setup byte.
        dq_d = (op_q == OP_CONFIG) ? `CMD_CONFIG : `CMD_LOCK_SETUP;
        if (acc_end) st_d = ST_CONF;
      end
      ST_CONF: begin
        dqoe_n_d = 1'b0;
        we_n_d = !strobe;
        unique case (op_q)
          OP_CONFIG: dq_d = {6'h00, code_q};
          OP_SET_BLOCK: dq_d = `CMD_BLOCK_CONF;
          OP_SET_MASTER: dq_d = `CMD_MASTER_CONF;
          default: dq_d = `CMD_CLEAR_CONF;
        endcase
        if (acc_end) st_d = (op_q == OP_CONFIG) ? ST_DONE : ST_POLL;
      end
      ST_POLL: begin
        // The flash now returns status on every read until it is ready.
        oe_n_d = !strobe;
        if (!pins_q[`PINS_RESET]) begin
          // A reset during a clear leaves the locks undefined.
          if (op_q == OP_CLEAR) unk_d = 1'b1;
          st_d = ST_DONE;
        end else if (acc_end) begin
          sr_d = flash_dq_i;
          if (flash_dq_i[`SR_READY]) begin
            st_d = ST_DONE;
            // Only a clean clear makes the lock values known again.
            if (op_q == OP_CLEAR && !flash_dq_i[`SR_CLR_ERR]) unk_d = 1'b0;
          end
        end
      end
      ST_DONE: begin
        cnt_d = 4'h0;
        done_d = 1'b1;
        st_d = ST_IDLE;
      end
    endcase
  end

  // Register sequencer state and every flash pin, so no pin glitches.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sr_q <= 8'h00;
      refused_q <= 1'b0;
      unk_q <= 1'b0;
      done_q <= 1'b0;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      ce_n_q <= 1'b1;
      dqoe_n_q <= 1'b1;
      dq_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sr_q <= sr_d;
      refused_q <= refused_d;
      unk_q <= unk_d;
      done_q <= done_d;
      we_n_q <= we_n_d;
      oe_n_q <= oe_n_d;
      ce_n_q <= ce_n_d;
      dqoe_n_q <= dqoe_n_d;
      dq_q <= dq_d;
    end
  end
  assign flash_we_n_o = we_n_q;
  assign flash_oe_n_o = oe_n_q;
  assign flash_ce_n_o = ce_n_q;
  assign flash_dq_oe_n_o = dqoe_n_q;
  assign flash_dq_o = dq_q;
  assign busy_o = (st_q != ST_IDLE);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_code_low;
    @(posedge mclk_i) disable iff (!rst_n)
      (st_q == ST_CONF && op_q == OP_CONFIG && cnt_q == 4'h2)
      |-> (flash_dq_o[1:0] == code_q) && !flash_we_n_o;
  endproperty
  a_code_low: assert property (p_code_low) else $error("config code wrong");
  property p_ready_first;
    @(posedge mclk_i) disable iff (!rst_n)
      (st_q == ST_PRD && acc_end && !flash_dq_i[`SR_READY]) |=> ##[1:2] st_q == ST_IDLE;
  endproperty
  a_ready_first: assert property (p_ready_first) else $error("busy flash written");
  property p_two_writes;
    @(posedge mclk_i) disable iff (!rst_n)
      (st_q == ST_SETUP && acc_end) |=> (st_q == ST_CONF) [*2];
  endproperty
  a_two_writes: assert property (p_two_writes) else $error("confirm missing");
  property p_abort_unknown;
    @(posedge mclk_i) disable iff (!rst_n)
      (st_q == ST_POLL && op_q == OP_CLEAR && !pins_q[`PINS_RESET]) |=> ##1 unk_q && done_q;
  endproperty
  a_abort_unknown: assert property (p_abort_unknown) else $error("abort not kept");
  property p_config_byte;
    @(posedge mclk_i) disable iff (!rst_n)
      (st_q == ST_SETUP && op_q == OP_CONFIG && cnt_q == 4'h2)
      |-> flash_dq_o == `CMD_CONFIG && $past(st_q) == ST_SETUP;
  endproperty
  a_config_byte: assert property (p_config_byte) else $error("config byte wrong");

endmodule : lock_host
`default_nettype wire

// ### hw/lock_host_params.svh
// Constants of the flash lock and status pin host controller.
`ifndef LOCK_HOST_PARAMS_SVH
`define LOCK_HOST_PARAMS_SVH
// Register byte offsets on the Wishbone side.
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_CODE 8'h08
`define REG_STAT 8'h0C
`define REG_PINS 8'h10
// Field positions.
`define CTRL_GO 3
`define PINS_RESET 0
`define PINS_HV 1
`define SR_READY 7
`define SR_CLR_ERR 5
// Reset values.
`define PINS_RST 2'h1
`define CODE_RST 2'h0
// Command bytes written to the flash.
`define CMD_CONFIG 8'hB8
`define CMD_READ_SR 8'h70
`define CMD_LOCK_SETUP 8'h60
`define CMD_BLOCK_CONF 8'h01
`define CMD_MASTER_CONF 8'hF1
`define CMD_CLEAR_CONF 8'hD0
// Strobe timing: period and least strobe width, in ns.
`define CLK_NS 50
`define STROBE_NS 100
`define STROBE_CYC ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ### hw/lock_host_pkg.sv
// Types shared by the flash lock and status pin host controller.
package lock_host_pkg;
  // Operations that software may order.
  typedef enum logic [2:0] {
    OP_CONFIG,
    OP_SET_BLOCK,
    OP_SET_MASTER,
    OP_CLEAR,
    OP_READ_SR
  } op_t;
endpackage : lock_host_pkg

// ### dv/flash_model.sv
// Behavioural flash device that answers the lock controller's strobes.
`timescale 1ns/1ns
`default_nettype none
`include "lock_host_params.svh"
module flash_model #(
  parameter int AW = 23, // Address width.
  parameter int BUSY_NS = 1000 // Run time of the write state machine.
) (
  input wire logic [AW-1:0] addr_i, // Address from the host.
  input wire logic [7:0] dq_i, // Resolved data wire.
  output logic [7:0] dq_o, // Data the device offers.
  input wire logic ce_n_i, // Chip enable, active low.
  input wire logic oe_n_i, // Output enable, active low.
  input wire logic we_n_i, // Write strobe, active low.
  input wire logic reset_pin_n_i, // Reset pin, active low.
  input wire logic hv_i, // Override voltage present.
  input wire logic lockout_i, // Program voltage at lockout.
  output logic status_out_pin_o // Status pin.
);
  logic [7:0] sr_q = 8'h80; // Status register, ready.
  logic [1:0] cfg_q = 2'h0; // Status pin mode.
  logic [63:0] lock_q = '0; // Block locks, all open at start.
  logic master_q = 1'b0; // Master lock, open at start.
  logic [7:0] first_q = 8'h00; // Pending setup byte.
  logic [7:0] op_q = 8'h00; // Confirmed lock operation.
  logic [5:0] blk_q = 6'h00; // Target block.

  // Reads always show status; off the bus the wire shows a changed value.
  assign dq_o = (!ce_n_i && !oe_n_i) ? sr_q : ~sr_q;
  // Level mode follows the ready bit; the pulse modes hold the pin high and never fire.
  assign status_out_pin_o = (cfg_q == 2'h0) ? sr_q[7] : 1'b1;

  // Command decoding on the rising write strobe.
  always @(posedge we_n_i) begin
    if (!ce_n_i && reset_pin_n_i) begin
      if (first_q == 8'hB8) begin
        if (dq_i[7:2] == 6'h00) cfg_q = dq_i[1:0];
        else sr_q = sr_q | 8'h30;
        first_q = 8'h00;
      end else if (first_q == `CMD_LOCK_SETUP) begin
        if (!sr_q[7]) begin
          sr_q = sr_q | 8'h30;
        end else if (dq_i inside {`CMD_BLOCK_CONF, `CMD_MASTER_CONF, `CMD_CLEAR_CONF}) begin
          op_q = dq_i;
          blk_q = addr_i[AW-1:AW-6];
          sr_q[7] = 1'b0;
        end else begin
          sr_q = sr_q | 8'h30;
        end
        first_q = 8'h00;
      end else begin
        first_q = dq_i;
      end
    end
  end

  // Completion of a lock operation after the machine's run time.
  always @(negedge sr_q[7]) begin
    #(BUSY_NS);
    if (!sr_q[7]) begin
      if (lockout_i) sr_q = sr_q | ((op_q == `CMD_CLEAR_CONF) ? 8'h28 : 8'h18);
      else if (op_q == `CMD_MASTER_CONF && !hv_i) sr_q = sr_q | 8'h12;
      else if (op_q == `CMD_MASTER_CONF) master_q = 1'b1;
      else if (master_q && !hv_i) sr_q = sr_q | ((op_q == `CMD_BLOCK_CONF) ? 8'h12 : 8'h22);
      else if (op_q == `CMD_BLOCK_CONF) lock_q[blk_q] = 1'b1;
      else lock_q = '0;
      sr_q[7] = 1'b1;
    end
  end

  // Reset pin restores the default mode; an interrupted clear leaves locks unknown.
  always @(negedge reset_pin_n_i) begin
    if (!sr_q[7] && op_q == `CMD_CLEAR_CONF) lock_q = 'x;
    cfg_q = 2'h0;
    sr_q = 8'h80;
    first_q = 8'h00;
  end
endmodule : flash_model
`default_nettype wire

// ### dv/lock_host_test.sv
// Self-checking bench of the lock controller against the flash model.
`timescale 1ns/1ns
`default_nettype none
`include "lock_host_params.svh"
module lock_host_test;
  logic mclk_i = 1'b0; // Clock.
  logic reset_n_i = 1'b0; // Reset, active low.
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // Bus request.
  logic [7:0] adr = 8'h00; // Bus address.
  logic [31:0] dat = 32'h0, rdat; // Bus data.
  logic lockout = 1'b0; // Program voltage at lockout.
  logic [31:0] dat_o; // Read data.
  logic ack; // Acknowledge.
  logic [22:0] faddr; // Flash address.
  logic [7:0] dq_c, dq_m, dq_w; // Data lines.
  logic dq_oe_n, ce_n, oe_n, we_n, reset_pin_n, hv, status_pin, busy; // Flash pins.
  int bad_count = 0, check_count = 0, cyc_count = 0; // Counters.

  // Controller drive wins the wire, otherwise the device's value.
  assign dq_w = !dq_oe_n ? dq_c : dq_m;

  lock_host u_lock_host (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .flash_addr_o(faddr), .flash_dq_i(dq_w),
    .flash_dq_o(dq_c), .flash_dq_oe_n_o(dq_oe_n), .flash_ce_n_o(ce_n),
    .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .reset_powerdown_pin_n_o(reset_pin_n),
    .override_high_voltage_o(hv), .status_out_pin_i(status_pin), .busy_o(busy));
  flash_model u_flash_model (.addr_i(faddr), .dq_i(dq_w), .dq_o(dq_m), .ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .reset_pin_n_i(reset_pin_n), .hv_i(hv), .lockout_i(lockout),
    .status_out_pin_o(status_pin));

  initial begin
    forever #25 mclk_i = ~mclk_i;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %0s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Classic cycle: hold everything until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge mclk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  // Orders one operation, waits for done and checks the status word.
  task automatic run_op(input logic [2:0] op, input logic [31:0] a, input logic [1:0] code,
                        input logic [7:0] sr);
    int n;
    wb(1'b1, `REG_ADDR, a);
    wb(1'b1, `REG_CODE, {30'h0, code});
    wb(1'b1, `REG_CTRL, {28'h0, 1'b1, op});
    // The sequencer must have left idle one edge after the start lands.
    @(posedge mclk_i);
    check("busy", 32'(busy), 32'h1);
    n = 0;
    do begin
      wb(1'b0, `REG_STAT, 32'h0);
      n++;
    end while (rdat[9] !== 1'b1 && n < 200);
    check("status word", 32'(rdat[11:0]), 32'({4'h2, sr}));
  endtask : run_op

  // Reset pulse on the flash clears its errors and its pin mode.
  task automatic flash_reset();
    wb(1'b1, `REG_PINS, 32'h0);
    wb(1'b1, `REG_PINS, 32'h1);
  endtask : flash_reset

  // A hang ends the run as a mismatch.
  always @(posedge mclk_i) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 30000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    wb(1'b0, `REG_PINS, 32'h0);
    check("pins reset", rdat, 32'h5);
    wb(1'b0, 8'h20, 32'h0);
    check("unmapped", rdat, 32'h0);
    $display("test reset done");
    for (int i = 1; i <= 4; i++) begin
      run_op(3'h0, 32'h0, 2'(i % 4), 8'h80);
      check("pin mode", 32'(u_flash_model.cfg_q), 32'(i % 4));
    end
    run_op(3'h0, 32'h0, 2'h2, 8'h80);
    flash_reset();
    check("mode after reset", 32'(u_flash_model.cfg_q), 32'h0);
    $display("test config done");
    run_op(3'h1, 32'h5 << 17, 2'h0, 8'h80);
    check("block lock", 32'(u_flash_model.lock_q[5]), 32'h1);
    run_op(3'h2, 32'h0, 2'h0, 8'h92);
    check("master no hv", 32'(u_flash_model.master_q), 32'h0);
    flash_reset();
    lockout <= 1'b1;
    run_op(3'h3, 32'h0, 2'h0, 8'hA8);
    check("frozen lock", 32'(u_flash_model.lock_q[5]), 32'h1);
    flash_reset();
    lockout <= 1'b0;
    $display("test lock done");
    wb(1'b1, `REG_PINS, 32'h3);
    run_op(3'h2, 32'h0, 2'h0, 8'h80);
    wb(1'b1, `REG_PINS, 32'h1);
    run_op(3'h1, 32'h7 << 17, 2'h0, 8'h92);
    check("gated lock", 32'(u_flash_model.lock_q[7]), 32'h0);
    flash_reset();
    run_op(3'h3, 32'h0, 2'h0, 8'hA2);
    flash_reset();
    // Pull the flash reset in the middle of a clear: the locks must be flagged unknown.
    wb(1'b1, `REG_CTRL, {28'h0, 1'b1, 3'h3});
    wait (u_flash_model.sr_q[7] === 1'b0);
    wb(1'b1, `REG_PINS, 32'h0);
    do wb(1'b0, `REG_STAT, 32'h0); while (rdat[9] !== 1'b1);
    check("abort flags", 32'(rdat[11:8]), 32'hA);
    // Only a repeated, clean clear makes the lock values known again.
    wb(1'b1, `REG_PINS, 32'h3);
    run_op(3'h3, 32'h0, 2'h0, 8'h80);
    check("cleared", 32'(|u_flash_model.lock_q), 32'h0);
    check("master kept", 32'(u_flash_model.master_q), 32'h1);
    wb(1'b1, `REG_PINS, 32'h1);
    run_op(3'h4, 32'h0, 2'h0, 8'h80);
    $display("test master done");
    report_and_stop();
  end
endmodule : lock_host_test
`default_nettype wire
